// ==== verilog/wp_clear_cfg.svh ====
/*
 * Constants for the write-protect clear register of one peripheral group:
 * register offset, reset value, mapped bits and each peripheral's bit position.
 * Assumes it is included by bare name from design and test files.
 */
`ifndef WP_CLEAR_CFG_SVH
`define WP_CLEAR_CFG_SVH

// ============================================================
// register placement
`define WP_ADDR_WIDTH 12
`define WP_CLR_OFFSET 12'h000
`define WP_DATA_WIDTH 32

// ============================================================
// reset and mapping
`define WP_RESET_VALUE 32'h0000_0000
`define WP_MAPPED_MASK 32'h0007_fffe
`define WP_READ_IDLE 32'h0000_0000

// ============================================================
// bit positions of the protected peripherals
`define WP_BIT_EVENT_ROUTING 1
`define WP_BIT_SERIAL_LO 2
`define WP_BIT_SERIAL_HI 7
`define WP_BIT_CTRL_TIMER_LO 8
`define WP_BIT_CTRL_TIMER_HI 10
`define WP_BIT_GEN_TIMER_LO 11
`define WP_BIT_GEN_TIMER_HI 15
`define WP_BIT_ADC 16
`define WP_BIT_COMPARATOR 17
`define WP_BIT_DAC 18

`endif

// ==== verilog/wp_pkg.sv ====
/*
 * Types shared by the write-protect clear block: the flag vector and the
 * register-port phase machine.
 * Assumes wp_clear_cfg.svh is on the include path.
 */
`include "wp_clear_cfg.svh"

package wp_pkg;
   typedef logic [`WP_DATA_WIDTH-1:0] prot_vec_t;
   typedef logic [`WP_ADDR_WIDTH-1:0] reg_addr_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SETUP  = 3'b010,
      ST_ACCESS = 3'b100
   } bus_state_t;
endpackage

// ==== verilog/prot_bank_if.sv ====
/*
 * Carrier between the register port logic and the protection flag bank.
 * Assumes both ends sit on the same clock.
 */
interface prot_bank_if;
   import wp_pkg::*;
   prot_vec_t clearMask;
   prot_vec_t setMask;
   prot_vec_t flags;

   modport ctrl (output clearMask, output setMask, input flags);
   modport bank (input clearMask, input setMask, output flags);
endinterface

// ==== verilog/wp_flag_bank.sv ====
/*
 * Bank of write-protect flags, one flip-flop per mapped peripheral bit.
 * Assumes clear and set masks are one-cycle pulses on sys_clk.
 */
`include "wp_clear_cfg.svh"

module wp_flag_bank #(
   parameter int WIDTH = `WP_DATA_WIDTH,
   parameter logic [WIDTH-1:0] MAPPED = `WP_MAPPED_MASK,
   parameter logic [WIDTH-1:0] RESET_VAL = `WP_RESET_VALUE
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   prot_bank_if.bank bankPort
);
   import wp_pkg::*;

   // ============================================================
   // one flag per bit; unmapped bits read as zero
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
         if (MAPPED[i]) begin : g_live
            logic flag_r;
            always_ff @(posedge sys_clk or negedge rst_b) begin
               if (!rst_b) begin
                  flag_r <= RESET_VAL[i];
               end else if (bankPort.setMask[i]) begin
                  // a set in the same cycle as a clear wins
                  flag_r <= 1'b1;
               end else if (bankPort.clearMask[i]) begin
                  flag_r <= 1'b0;
               end
            end
            assign bankPort.flags[i] = flag_r;
         end else begin : g_dead
            assign bankPort.flags[i] = 1'b0;
         end
      end
   endgenerate
endmodule

// ==== verilog/peripheral_write_protect_clear.sv ====
/*
 * Write-protect clear register for the timer, serial, event and analog
 * peripheral group, behind a zero-wait APB register port.
 * Assumes APB requests on sys_clk from the bridge and a one-cycle set pulse
 * vector from the companion set register logic.
 * Nothing on the bus can raise a flag; protection only rises through that vector.
 */
`include "wp_clear_cfg.svh"

// How it works
// - a zero written to any bit leaves that peripheral's protection unchanged
// - writing one clears the flag unless a set pulse arrives in the same cycle; flag reads 1 protected, 0 unprotected
// - bits 11 to 15 guard general timers zero to four in order
// - bits 8 to 10 guard control timers zero to two in order
// - bits 2 to 7 guard serial units zero to five in order
module peripheral_write_protect_clear (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire wp_pkg::reg_addr_t paddr,
   input wire logic [3:0] pstrb,
   input wire wp_pkg::prot_vec_t pwdata,
   output wp_pkg::prot_vec_t prdata,
   output logic pready,
   output logic pslverr,
   input wire wp_pkg::prot_vec_t protectSet,
   output wp_pkg::prot_vec_t protectFlags,
   output logic eventRoutingProtect,
   output logic [5:0] serialUnitProtect,
   output logic [2:0] controlTimerProtect,
   output logic [4:0] generalTimerProtect,
   output logic adcProtect,
   output logic analogComparatorProtect,
   output logic dacProtect
);
   import wp_pkg::*;

   // ============================================================
   // decode helpers
   function automatic logic regHit(input reg_addr_t addr);
      reg_addr_t offset;
      // word aligned: the two low address bits are ignored
      offset = `WP_CLR_OFFSET;
      regHit = (addr[`WP_ADDR_WIDTH-1:2] == offset[`WP_ADDR_WIDTH-1:2]);
   endfunction

   function automatic prot_vec_t laneMask(input logic [3:0] strb);
      prot_vec_t m;
      m = '0;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      laneMask = m;
   endfunction

   // a one outside every peripheral group names nothing and is dropped
   // rather than stored
   function automatic prot_vec_t spanMask(input int lo, input int hi);
      prot_vec_t m;
      m = '0;
      for (int k = 0; k < `WP_DATA_WIDTH; k++) begin
         m[k] = (k >= lo) && (k <= hi);
      end
      spanMask = m;
   endfunction

   // ============================================================
   // signals
   bus_state_t state_r;
   bus_state_t state_nxt;
   prot_vec_t rdData_r;
   prot_vec_t rdData_nxt;
   logic err_r;
   logic err_nxt;
   logic setupPhase;
   logic accessPhase;
   logic writeHit;
   prot_vec_t clearBits;
   prot_vec_t clearableBits;

   prot_bank_if bankBus ();

   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;

   // ============================================================
   // phase tracking
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            // an access phase with no setup before it stays refused
            if (setupPhase) begin
               state_nxt = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (accessPhase) begin
               state_nxt = ST_ACCESS;
            end else if (!psel) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_ACCESS: begin
            // zero wait: a new setup may follow with psel held high
            if (setupPhase) begin
               state_nxt = ST_SETUP;
            end else begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            // an upset code falls back to idle
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ============================================================
   // read data and error are captured in the setup cycle; prdata comes straight
   // from a flip-flop, pslverr is err_r gated with the access phase and state_r
   always_comb begin
      err_nxt = err_r;
      if (setupPhase) begin
         err_nxt = !regHit(paddr);
      end
   end

   always_comb begin
      rdData_nxt = rdData_r;
      if (setupPhase) begin
         if (!pwrite && regHit(paddr)) begin
            rdData_nxt = bankBus.flags;
         end else begin
            rdData_nxt = `WP_READ_IDLE;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdData_r <= `WP_READ_IDLE;
      end else begin
         rdData_r <= rdData_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         err_r <= 1'b0;
      end else begin
         err_r <= err_nxt;
      end
   end

   assign prdata = rdData_r;
   // zero wait: every access completes in its first cycle
   assign pready = accessPhase;
   // an access without a preceding setup cycle is also refused
   assign pslverr = accessPhase && (err_r || (state_r != ST_SETUP));

   // ============================================================
   // write-one-to-clear: only ones in enabled byte lanes reach the bank,
   // zeros produce no clear at all
   assign writeHit = accessPhase && pwrite && !err_r && (state_r == ST_SETUP);
   assign clearableBits = spanMask(`WP_BIT_GEN_TIMER_LO, `WP_BIT_GEN_TIMER_HI)
      | spanMask(`WP_BIT_CTRL_TIMER_LO, `WP_BIT_CTRL_TIMER_HI)
      | spanMask(`WP_BIT_SERIAL_LO, `WP_BIT_SERIAL_HI)
      | spanMask(`WP_BIT_EVENT_ROUTING, `WP_BIT_EVENT_ROUTING)
      | spanMask(`WP_BIT_ADC, `WP_BIT_DAC);

   assign clearBits = writeHit ? (pwdata & laneMask(pstrb) & clearableBits) : '0;

   assign bankBus.clearMask = clearBits;
   assign bankBus.setMask = protectSet & `WP_MAPPED_MASK;

   wp_flag_bank #(
      .WIDTH(`WP_DATA_WIDTH),
      .MAPPED(`WP_MAPPED_MASK),
      .RESET_VAL(`WP_RESET_VALUE)
   ) u_bank (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .bankPort(bankBus.bank)
   );

   // ============================================================
   // per-peripheral protection levels, all straight from the flags
   assign protectFlags = bankBus.flags;
   assign eventRoutingProtect = bankBus.flags[`WP_BIT_EVENT_ROUTING];
   // unit n of each group sits n bits above the group's lowest bit
   localparam int SerialUnits = `WP_BIT_SERIAL_HI - `WP_BIT_SERIAL_LO + 1;
   localparam int CtrlTimers = `WP_BIT_CTRL_TIMER_HI - `WP_BIT_CTRL_TIMER_LO + 1;
   localparam int GenTimers = `WP_BIT_GEN_TIMER_HI - `WP_BIT_GEN_TIMER_LO + 1;

   genvar n;
   generate
      for (n = 0; n < SerialUnits; n = n + 1) begin : g_serial
         assign serialUnitProtect[n] = bankBus.flags[`WP_BIT_SERIAL_LO + n];
      end
      for (n = 0; n < CtrlTimers; n = n + 1) begin : g_ctrl
         assign controlTimerProtect[n] = bankBus.flags[`WP_BIT_CTRL_TIMER_LO + n];
      end
      for (n = 0; n < GenTimers; n = n + 1) begin : g_gen
         assign generalTimerProtect[n] = bankBus.flags[`WP_BIT_GEN_TIMER_LO + n];
      end
   endgenerate
   assign adcProtect = bankBus.flags[`WP_BIT_ADC];
   assign analogComparatorProtect = bankBus.flags[`WP_BIT_COMPARATOR];
   assign dacProtect = bankBus.flags[`WP_BIT_DAC];
endmodule

// ==== test/peripheral_write_protect_clear_assertions.sv ====
/* Checker for the write-protect clear block, bound to its top ports.
   Assumes wp_pkg is compiled first and one clock domain. */
module wp_clear_checker (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire wp_pkg::reg_addr_t paddr,
   input wire logic [3:0] pstrb,
   input wire wp_pkg::prot_vec_t pwdata,
   input wire wp_pkg::prot_vec_t prdata,
   input wire wp_pkg::prot_vec_t protectSet,
   input wire wp_pkg::prot_vec_t protectFlags,
   input wire logic eventRoutingProtect,
   input wire logic [5:0] serialUnitProtect,
   input wire logic [2:0] controlTimerProtect,
   input wire logic [4:0] generalTimerProtect,
   input wire logic adcProtect,
   input wire logic analogComparatorProtect,
   input wire logic dacProtect
);
   import wp_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ===
   // register access steps
   sequence setupHit;
      psel && !penable && paddr[11:2] == 10'h000;
   endsequence
   sequence fullClear;
      setupHit ##1 psel && penable && pwrite && pstrb == 4'hf && protectSet == '0;
   endsequence
   a_one_clears: assert property (fullClear |=> (protectFlags & $past(pwdata)) == '0)
      else $error("flag survived a clearing write");
   a_zero_bits_kept: assert property (fullClear |=>
      (protectFlags & ~$past(pwdata)) == ($past(protectFlags) & ~$past(pwdata)))
      else $error("a zero bit changed its flag");
   a_zero_keeps: assert property ((protectSet == '0 && !(psel && penable && pwrite))
      |=> $stable(protectFlags)) else $error("flags moved without cause");
   a_read_data: assert property (setupHit ##1 (psel && penable && !pwrite)
      |-> prdata == $past(protectFlags)) else $error("read data not the flag state");
   // ===
   // bit mapping
   a_gen_timer_map: assert property (generalTimerProtect == protectFlags[15:11])
      else $error("general timer outputs misplaced");
   a_ctrl_timer_map: assert property (controlTimerProtect == protectFlags[10:8])
      else $error("control timer outputs misplaced");
   a_serial_map: assert property (serialUnitProtect == protectFlags[7:2])
      else $error("serial unit outputs misplaced");
   a_misc_map: assert property ({dacProtect, analogComparatorProtect, adcProtect,
      eventRoutingProtect} == {protectFlags[18:16], protectFlags[1]})
      else $error("event or analog outputs misplaced");
   a_unmapped_zero: assert property (protectFlags[31:19] == '0 && !protectFlags[0])
      else $error("unmapped flag bit set");
endmodule

bind peripheral_write_protect_clear wp_clear_checker u_wp_clear_checker (
   .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pstrb(pstrb), .pwdata(pwdata), .prdata(prdata), .protectSet(protectSet),
   .protectFlags(protectFlags), .eventRoutingProtect(eventRoutingProtect),
   .serialUnitProtect(serialUnitProtect), .controlTimerProtect(controlTimerProtect),
   .generalTimerProtect(generalTimerProtect), .adcProtect(adcProtect),
   .analogComparatorProtect(analogComparatorProtect), .dacProtect(dacProtect));

// ==== test/test_peripheral_write_protect_clear.sv ====
/* Self-checking bench for the write-protect clear block over its register port.
   Assumes the design files and wp_clear_cfg.svh on the include path. */
`include "wp_clear_cfg.svh"
module test_peripheral_write_protect_clear;
   timeunit 1ns;
   timeprecision 1ps;
   import wp_pkg::*;
   logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic eventRoutingProtect, adcProtect, analogComparatorProtect, dacProtect;
   logic [3:0] pstrb;
   logic [5:0] serialUnitProtect;
   logic [2:0] controlTimerProtect;
   logic [4:0] generalTimerProtect;
   reg_addr_t paddr;
   prot_vec_t pwdata, prdata, protectSet, protectFlags, expFlags, seen;
   int n_errors = 0;
   int checked = 0;

   peripheral_write_protect_clear u_peripheral_write_protect_clear (
      .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pstrb(pstrb), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .protectSet(protectSet), .protectFlags(protectFlags),
      .eventRoutingProtect(eventRoutingProtect), .serialUnitProtect(serialUnitProtect),
      .controlTimerProtect(controlTimerProtect), .generalTimerProtect(generalTimerProtect),
      .adcProtect(adcProtect), .analogComparatorProtect(analogComparatorProtect),
      .dacProtect(dacProtect));

   // ===
   // access tasks
   task check(input prot_vec_t got, input prot_vec_t exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   // request held until the edge that samples pready high; answer taken at that edge
   task access(input logic wr, input reg_addr_t a, input prot_vec_t d, input logic err);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      check(32'({pready, pslverr}), 32'({1'b1, err}));
      seen = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task checkFlags;
      @(negedge sys_clk);
      check(protectFlags, expFlags);
      check(32'({dacProtect, analogComparatorProtect, adcProtect, generalTimerProtect,
         controlTimerProtect, serialUnitProtect, eventRoutingProtect, 1'b0}), expFlags);
      access(1'b0, 12'h000, '0, 1'b0);
      check(seen, expFlags);
   endtask

   task setAll;
      @(posedge sys_clk);
      protectSet <= '1;
      @(posedge sys_clk);
      protectSet <= '0;
      expFlags = `WP_MAPPED_MASK;
   endtask

   task test_done;
      if (n_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ===
   // clock, watchdog and tests
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (3000) @(posedge sys_clk);
      n_errors++;
      test_done;
   end

   initial begin
      {rst_b, psel, penable, pwrite, paddr, pstrb, pwdata, protectSet} = '0;
      expFlags = '0;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      pstrb <= 4'hf;
      checkFlags;
      setAll;
      checkFlags;
      // zeros in mapped bits and ones only in unmapped bits change nothing
      access(1'b1, 12'h000, ~`WP_MAPPED_MASK, 1'b0);
      checkFlags;
      access(1'b1, 12'h100, '1, 1'b1);
      checkFlags;
      for (int b = 1; b <= 18; b++) begin
         access(1'b1, 12'h000, 32'h1 << b, 1'b0);
         expFlags[b] = 1'b0;
         checkFlags;
      end
      setAll;
      access(1'b1, 12'h000, 32'h0005_5554, 1'b0);
      expFlags = 32'h0002_aaaa;
      checkFlags;
      // disabled byte lanes clear nothing; low address bits are ignored
      setAll;
      pstrb <= 4'h2;
      access(1'b1, 12'h002, '1, 1'b0);
      pstrb <= 4'hf;
      expFlags = 32'h0007_00fe;
      checkFlags;
      @(posedge sys_clk);
      rst_b <= 1'b0;
      @(posedge sys_clk);
      rst_b <= 1'b1;
      expFlags = '0;
      checkFlags;
      test_done;
   end
endmodule
